//--- shared/net_ind_pkg.sv
// constants, register map and carrier types of the network status indicators
package net_ind_pkg;

    // device clock and indicator stretch time
    localparam int CLK_HZ         = 100_000_000;
    localparam int STRETCH_MS     = 50;
    localparam int STRETCH_CYCLES = CLK_HZ / 1000 * STRETCH_MS;

    // consecutive reversed-polarity events that light the polarity indicator
    localparam int POL_PULSES  = 7;
    localparam int POL_PACKETS = 3;
    localparam int PULSE_CW    = $clog2(POL_PULSES + 1);
    localparam int PKT_CW      = $clog2(POL_PACKETS + 1);

    // register port
    localparam int AW = 4;
    localparam int DW = 32;
    localparam logic [AW-1:0] CTRL_ADDR     = 4'h0;
    localparam logic [AW-1:0] STATE_ADDR    = 4'h4;
    localparam logic [AW-1:0] IRQ_ST_ADDR   = 4'h8;
    localparam logic [AW-1:0] IRQ_MASK_ADDR = 4'hC;

    // media-type code that selects thin coaxial cable
    localparam logic [1:0] MEDIA_THIN = 2'h1;

    // interrupt status bit positions
    localparam int IRQ_W    = 5;
    localparam int IRQ_TX   = 0;
    localparam int IRQ_RX   = 1;
    localparam int IRQ_COL  = 2;
    localparam int IRQ_POL  = 3;
    localparam int IRQ_LINK = 4;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

    typedef struct packed {
        logic       link_test_en;
        logic       twisted_pair_mode;
        logic [1:0] media_type_sel;
    } ctrl_s;

    // link test enabled, AUI mode, no thin cable
    localparam logic [3:0] CTRL_RESET = 4'h8;

    typedef struct packed {
        logic thin_cable;
        logic good_link_indicator_n;
        logic polarity_indicator_n;
        logic collision_indicator_n;
        logic receive_indicator_n;
        logic transmit_indicator_n;
    } ind_s;

endpackage : net_ind_pkg

//--- rtl/activity_stretcher.sv
// one activity indicator held low for a fixed count after its last trigger
`timescale 1ns/1ps
`default_nettype none

module activity_stretcher
    import net_ind_pkg::*;
#(
    parameter int HOLD = STRETCH_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic trig_i,
    output var  logic ind_n_o
);

    localparam int            W    = $clog2(HOLD + 1);
    localparam logic [W-1:0]  LOAD = W'(HOLD - 1);
    localparam logic [W-1:0]  ZERO = '0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_HOLD = 2'b10
    } st_e;

    st_e          st_q;
    st_e          st_d;
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         ind_n_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        ind_n_d = ind_n_o;
        case (st_q)
            ST_IDLE: begin
                if (trig_i) begin
                    st_d    = ST_HOLD;
                    cnt_d   = LOAD;
                    ind_n_d = 1'b0;
                end
            end
            ST_HOLD: begin
                if (trig_i) begin
                    cnt_d = LOAD;
                end else if (cnt_q == ZERO) begin
                    st_d    = ST_IDLE;
                    ind_n_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                st_d    = ST_IDLE;
                cnt_d   = ZERO;
                ind_n_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q    <= ST_IDLE;
            cnt_q   <= ZERO;
            ind_n_o <= 1'b1;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            ind_n_o <= ind_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_trig_lights;
        trig_i |=> !ind_n_o ##1 !ind_n_o;
    endproperty
    a_trig_lights: assert property (p_trig_lights)
        else $error("indicator not lit after trigger");

    property p_restart;
        trig_i |=> (cnt_q == LOAD) && (st_q == ST_HOLD);
    endproperty
    a_restart: assert property (p_restart)
        else $error("stretch count not restarted by trigger");

    property p_expire;
        (st_q == ST_HOLD) && (cnt_q == ZERO) && !trig_i |=> ind_n_o && (st_q == ST_IDLE);
    endproperty
    a_expire: assert property (p_expire)
        else $error("indicator not released at end of stretch");

    property p_countdown;
        (st_q == ST_HOLD) && (cnt_q != ZERO) && !trig_i
            |=> !ind_n_o && (cnt_q == $past(cnt_q) - 1'b1);
    endproperty
    a_countdown: assert property (p_countdown)
        else $error("stretch count did not step down");

    c_retrigger: cover property ((st_q == ST_HOLD) && (cnt_q != LOAD) && trig_i);

endmodule : activity_stretcher

`default_nettype wire

//--- rtl/net_status_indicators.sv
// network status indicators with register port and interrupt
// Summary of operation
// - seven reversed link pulses in a row light the polarity indicator
// - three reversed packets in a row also light the polarity indicator
// - any transmit lights the transmit indicator for about 50 ms
// - valid receive data lights the receive indicator for about 50 ms
// - a collision lights the collision indicator for about 50 ms
// - good-link indicator off in AUI mode, or link test on and bad
// - good-link indicator on whenever link testing is disabled in twisted-pair mode
// - good-link indicator on in twisted-pair mode when link test is on and link good
// - thin-cable output high exactly when media type selects thin coax
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module net_status_indicators
    import net_ind_pkg::*;
#(
    parameter int STRETCH = STRETCH_CYCLES
) (
    input  wire logic          CLOCK_I,
    input  wire logic          ARST_N_I,
    input  wire logic [AW-1:0] ADDR_I,
    input  wire logic [DW-1:0] WDATA_I,
    input  wire logic          WR_I,
    input  wire logic          RD_I,
    output var  logic [DW-1:0] RDATA_O,
    output var  logic          IRQ_O,
    input  wire logic          TX_ACTIVE_I,
    input  wire logic          RX_VALID_I,
    input  wire logic          COLLISION_I,
    input  wire logic          LINK_PULSE_I,
    input  wire logic          PULSE_REVERSED_I,
    input  wire logic          PACKET_DONE_I,
    input  wire logic          PACKET_REVERSED_I,
    input  wire logic          LINK_GOOD_I,
    output logic               TRANSMIT_INDICATOR_N_O,
    output logic               RECEIVE_INDICATOR_N_O,
    output logic               COLLISION_INDICATOR_N_O,
    output var  logic          POLARITY_INDICATOR_N_O,
    output var  logic          GOOD_LINK_INDICATOR_N_O,
    output var  logic          THIN_CABLE_O
);

    localparam logic [PULSE_CW-1:0] PULSE_MAX = PULSE_CW'(POL_PULSES);
    localparam logic [PKT_CW-1:0]   PKT_MAX   = PKT_CW'(POL_PACKETS);

    ctrl_s               ctrl_q;
    ctrl_s               ctrl_d;
    logic [IRQ_W-1:0]    irq_st_q;
    logic [IRQ_W-1:0]    irq_st_d;
    logic [IRQ_W-1:0]    irq_mask_q;
    logic [IRQ_W-1:0]    irq_mask_d;
    logic [IRQ_W-1:0]    ev;
    logic [IRQ_W-1:0]    w1c;
    logic                irq_d;
    logic [DW-1:0]       rdata_d;
    logic [2:0]          act;
    logic [2:0]          act_q;
    logic [2:0]          ind_n;
    logic [PULSE_CW-1:0] pulse_cnt_q;
    logic [PULSE_CW-1:0] pulse_cnt_d;
    logic [PKT_CW-1:0]   pkt_cnt_q;
    logic [PKT_CW-1:0]   pkt_cnt_d;
    logic                pol_n_d;
    logic                pol_set;
    logic                pol_clr;
    logic                gl_n_d;
    logic                thin_d;
    ind_s                state;

    assign act = {COLLISION_I, RX_VALID_I, TX_ACTIVE_I};

    ////////////////////////////////////////////////////////////////////////
    // activity indicators: transmit, receive, collision
    for (genvar g = 0; g < 3; g++) begin : g_act
        activity_stretcher #(
            .HOLD (STRETCH)
        ) u_stretch (
            .clk_i    (CLOCK_I),
            .arst_n_i (ARST_N_I),
            .trig_i   (act[g]),
            .ind_n_o  (ind_n[g])
        );
    end

    assign TRANSMIT_INDICATOR_N_O  = ind_n[0];
    assign RECEIVE_INDICATOR_N_O   = ind_n[1];
    assign COLLISION_INDICATOR_N_O = ind_n[2];

    ////////////////////////////////////////////////////////////////////////
    // polarity detection
    always_comb begin
        pulse_cnt_d = pulse_cnt_q;
        pkt_cnt_d   = pkt_cnt_q;
        if (LINK_PULSE_I) begin
            if (!PULSE_REVERSED_I) begin
                pulse_cnt_d = '0;
            end else if (pulse_cnt_q != PULSE_MAX) begin
                pulse_cnt_d = pulse_cnt_q + 1'b1;
            end
        end
        if (PACKET_DONE_I) begin
            if (!PACKET_REVERSED_I) begin
                pkt_cnt_d = '0;
            end else if (pkt_cnt_q != PKT_MAX) begin
                pkt_cnt_d = pkt_cnt_q + 1'b1;
            end
        end
        pol_set = (pulse_cnt_d == PULSE_MAX) || (pkt_cnt_d == PKT_MAX);
        pol_clr = (LINK_PULSE_I && !PULSE_REVERSED_I)
               || (PACKET_DONE_I && !PACKET_REVERSED_I);
        pol_n_d = POLARITY_INDICATOR_N_O;
        if (pol_set) begin
            pol_n_d = 1'b0;
        end else if (pol_clr) begin
            pol_n_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link status and thin-cable output
    always_comb begin
        if (!ctrl_q.twisted_pair_mode) begin
            gl_n_d = 1'b1;
        end else if (!ctrl_q.link_test_en) begin
            gl_n_d = 1'b0;
        end else begin
            gl_n_d = !LINK_GOOD_I;
        end
        thin_d = (ctrl_q.media_type_sel == MEDIA_THIN);
    end

    ////////////////////////////////////////////////////////////////////////
    // register port and interrupt
    always_comb begin
        state = '{
            thin_cable:            THIN_CABLE_O,
            good_link_indicator_n: GOOD_LINK_INDICATOR_N_O,
            polarity_indicator_n:  POLARITY_INDICATOR_N_O,
            collision_indicator_n: ind_n[2],
            receive_indicator_n:   ind_n[1],
            transmit_indicator_n:  ind_n[0]
        };
        ev           = '0;
        ev[IRQ_TX]   = act[0] && !act_q[0];
        ev[IRQ_RX]   = act[1] && !act_q[1];
        ev[IRQ_COL]  = act[2] && !act_q[2];
        ev[IRQ_POL]  = POLARITY_INDICATOR_N_O && !pol_n_d;
        ev[IRQ_LINK] = GOOD_LINK_INDICATOR_N_O != gl_n_d;
        ctrl_d       = ctrl_q;
        irq_mask_d   = irq_mask_q;
        w1c          = '0;
        if (WR_I) begin
            case (ADDR_I)
                CTRL_ADDR:     ctrl_d     = ctrl_s'(WDATA_I[3:0]);
                IRQ_ST_ADDR:   w1c        = WDATA_I[IRQ_W-1:0];
                IRQ_MASK_ADDR: irq_mask_d = WDATA_I[IRQ_W-1:0];
                default:       ctrl_d     = ctrl_q;
            endcase
        end
        // a new event wins over a clear in the same cycle
        irq_st_d = (irq_st_q & ~w1c) | ev;
        irq_d    = |(irq_st_d & irq_mask_d);
        rdata_d  = '0;
        if (RD_I) begin
            case (ADDR_I)
                CTRL_ADDR:     rdata_d = DW'(ctrl_q);
                STATE_ADDR:    rdata_d = DW'(state);
                IRQ_ST_ADDR:   rdata_d = DW'(irq_st_q);
                IRQ_MASK_ADDR: rdata_d = DW'(irq_mask_q);
                default:       rdata_d = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctrl_q                  <= ctrl_s'(CTRL_RESET);
            irq_st_q                <= IRQ_RESET;
            irq_mask_q              <= IRQ_RESET;
            IRQ_O                   <= 1'b0;
            RDATA_O                 <= '0;
            act_q                   <= '0;
            pulse_cnt_q             <= '0;
            pkt_cnt_q               <= '0;
            POLARITY_INDICATOR_N_O  <= 1'b1;
            GOOD_LINK_INDICATOR_N_O <= 1'b1;
            THIN_CABLE_O            <= 1'b0;
        end else begin
            ctrl_q                  <= ctrl_d;
            irq_st_q                <= irq_st_d;
            irq_mask_q              <= irq_mask_d;
            IRQ_O                   <= irq_d;
            RDATA_O                 <= rdata_d;
            act_q                   <= act;
            pulse_cnt_q             <= pulse_cnt_d;
            pkt_cnt_q               <= pkt_cnt_d;
            POLARITY_INDICATOR_N_O  <= pol_n_d;
            GOOD_LINK_INDICATOR_N_O <= gl_n_d;
            THIN_CABLE_O            <= thin_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!ARST_N_I);

    property p_pol_pulses;
        (pulse_cnt_q == PULSE_MAX - 1'b1) && LINK_PULSE_I && PULSE_REVERSED_I
            |=> !POLARITY_INDICATOR_N_O;
    endproperty
    a_pol_pulses: assert property (p_pol_pulses)
        else $error("polarity not lit after seven reversed pulses");

    property p_pol_packets;
        (pkt_cnt_q == PKT_MAX - 1'b1) && PACKET_DONE_I && PACKET_REVERSED_I
            |=> !POLARITY_INDICATOR_N_O;
    endproperty
    a_pol_packets: assert property (p_pol_packets)
        else $error("polarity not lit after three reversed packets");

    property p_tx;
        TX_ACTIVE_I |=> !TRANSMIT_INDICATOR_N_O;
    endproperty
    a_tx: assert property (p_tx)
        else $error("transmit indicator not lit");

    property p_rx;
        RX_VALID_I |=> !RECEIVE_INDICATOR_N_O;
    endproperty
    a_rx: assert property (p_rx)
        else $error("receive indicator not lit");

    property p_col;
        COLLISION_I |=> !COLLISION_INDICATOR_N_O;
    endproperty
    a_col: assert property (p_col)
        else $error("collision indicator not lit");

    property p_link_off;
        !ctrl_q.twisted_pair_mode
            || (ctrl_q.link_test_en && !LINK_GOOD_I) |=> GOOD_LINK_INDICATOR_N_O;
    endproperty
    a_link_off: assert property (p_link_off)
        else $error("good-link indicator not off");

    property p_link_untested;
        ctrl_q.twisted_pair_mode && !ctrl_q.link_test_en |=> !GOOD_LINK_INDICATOR_N_O;
    endproperty
    a_link_untested: assert property (p_link_untested)
        else $error("good-link indicator not on with link test disabled");

    property p_link_good;
        ctrl_q.twisted_pair_mode && ctrl_q.link_test_en && LINK_GOOD_I
            |=> !GOOD_LINK_INDICATOR_N_O;
    endproperty
    a_link_good: assert property (p_link_good)
        else $error("good-link indicator not on with good link");

    property p_thin;
        ##1 (THIN_CABLE_O == ($past(ctrl_q.media_type_sel) == MEDIA_THIN));
    endproperty
    a_thin: assert property (p_thin)
        else $error("thin-cable output disagrees with media type");

    property p_irq;
        ##1 (IRQ_O == |(irq_st_q & irq_mask_q));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output disagrees with status and mask");

    c_pol_pulses: cover property (pulse_cnt_q == PULSE_MAX && !POLARITY_INDICATOR_N_O);
    c_pol_packets: cover property (pkt_cnt_q == PKT_MAX && !POLARITY_INDICATOR_N_O);
    c_link_good: cover property (ctrl_q.twisted_pair_mode && !GOOD_LINK_INDICATOR_N_O);
    c_irq: cover property (IRQ_O);

endmodule : net_status_indicators

`default_nettype wire

//--- tb/led_board.sv
// board side of the indicators: lamps lit by low pins, converter enable
`timescale 1ns/1ps
`default_nettype none

module led_board
    import net_ind_pkg::*;
(
    input  wire ind_s       pins_i,
    output var  logic [5:0] lamp_o
);
    // lamp order follows the state register: tx, rx, col, pol, link, converter
    always_comb begin
        lamp_o = {pins_i.thin_cable, ~pins_i.good_link_indicator_n,
                  ~pins_i.polarity_indicator_n, ~pins_i.collision_indicator_n,
                  ~pins_i.receive_indicator_n, ~pins_i.transmit_indicator_n};
    end
endmodule : led_board

`default_nettype wire

//--- tb/tb.sv
// self-checking bench of the network status indicators
`timescale 1ns/1ps
`default_nettype none

module tb
    import net_ind_pkg::*;
;
    localparam int ST = 8;
    typedef struct {string nm; logic [DW-1:0] v;} note_s;

    logic          clk;
    logic          arst_n;
    logic          wr;
    logic          rd;
    logic          rd_d;
    logic          lgood;
    logic          irq;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic [2:0]    act;
    logic          lp;
    logic          lrev;
    logic          pd;
    logic          prev;
    ind_s          pins;
    logic [5:0]    lamp;
    int            fails;
    int            checked;
    int            cyc;
    int            g;
    note_s         notes[$];

    net_status_indicators #(.STRETCH(ST)) uut (
        .CLOCK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq),
        .TX_ACTIVE_I(act[0]), .RX_VALID_I(act[1]), .COLLISION_I(act[2]),
        .LINK_PULSE_I(lp), .PULSE_REVERSED_I(lrev), .PACKET_DONE_I(pd),
        .PACKET_REVERSED_I(prev), .LINK_GOOD_I(lgood),
        .TRANSMIT_INDICATOR_N_O(pins.transmit_indicator_n),
        .RECEIVE_INDICATOR_N_O(pins.receive_indicator_n),
        .COLLISION_INDICATOR_N_O(pins.collision_indicator_n),
        .POLARITY_INDICATOR_N_O(pins.polarity_indicator_n),
        .GOOD_LINK_INDICATOR_N_O(pins.good_link_indicator_n),
        .THIN_CABLE_O(pins.thin_cable)
    );

    led_board brd (.pins_i(pins), .lamp_o(lamp));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] s);
        checked++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic look(input logic [5:0] e, input string nm);
        @(negedge clk);
        chk(nm, {26'h0, e}, {26'h0, lamp});
    endtask : look

    function automatic logic [DW-1:0] st(input logic [5:0] l);
        return {26'h0, l[5], ~l[4:0]};
    endfunction : st

    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [AW-1:0] a, input logic [DW-1:0] e, input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        notes.push_back('{nm, e});
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg

    // a gap of 1 to ST retriggers before the stretch runs out
    task automatic act_hit(input int i, input int gap);
        @(posedge clk);
        act[i] <= 1'b1;
        @(posedge clk);
        act[i] <= 1'b0;
        if (gap > 0) begin
            tick(gap - 1);
            act[i] <= 1'b1;
            @(posedge clk);
            act[i] <= 1'b0;
        end
    endtask : act_hit

    task automatic pol_ev(input bit pkt, input int n, input bit rev);
        repeat (n) begin
            @(posedge clk);
            lp <= !pkt;
            lrev <= rev;
            pd <= pkt;
            prev <= rev;
        end
        @(posedge clk);
        lp <= 1'b0;
        pd <= 1'b0;
    endtask : pol_ev

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        rd_d <= rd;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            close_out();
        end
    end

    // read results are matched against the oldest note
    always @(negedge clk) begin : mon
        note_s n;
        if (rd_d === 1'b1) begin
            if (notes.size() == 0) begin
                chk("note queue", 1, 0);
            end else begin
                n = notes.pop_front();
                chk(n.nm, n.v, rdata);
            end
        end else if (rdata !== '0) begin
            chk("idle read data", 0, rdata);
        end
    end

    initial begin
        {arst_n, wr, rd, lgood, lp, lrev, pd, prev, act} = '0;
        addr = '0;
        wdata = '0;
        void'($urandom(32'h5f7c));
        tick(6);
        arst_n <= 1'b1;
        look(6'h00, "reset lamps");
        rd_reg(CTRL_ADDR, 32'h0000_0008, "ctrl reset");
        rd_reg(STATE_ADDR, st(6'h00), "state reset");
        rd_reg(IRQ_ST_ADDR, 32'h0000_0000, "status reset");
        rd_reg(IRQ_MASK_ADDR, 32'h0000_0000, "mask reset");
        rd_reg(4'h2, 32'h0000_0000, "unmapped");
        wr_reg(STATE_ADDR, 32'h0000_0000);
        rd_reg(STATE_ADDR, st(6'h00), "state read only");
        for (int m = 0; m < 4; m++) begin
            wr_reg(CTRL_ADDR, 32'h0000_0008 | m);
            tick(1);
            look({m == 1, 5'h00}, "thin cable");
            rd_reg(STATE_ADDR, st({m == 1, 5'h00}), "state thin");
        end
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            lgood <= k[0];
            wr_reg(CTRL_ADDR, {28'h0, k[1], k[2], 2'b00});
            tick(1);
            look({1'b0, k[2] && (!k[1] || k[0]), 4'h0}, "good link");
        end
        rd_reg(IRQ_ST_ADDR, 32'h0000_0010, "link status");
        wr_reg(IRQ_ST_ADDR, 32'h0000_001F);
        rd_reg(IRQ_ST_ADDR, 32'h0000_0000, "status cleared");
        act_hit(0, 0);
        tick(2);
        chk("masked irq", 0, {31'h0, irq});
        rd_reg(IRQ_ST_ADDR, 32'h0000_0001, "tx status");
        wr_reg(IRQ_MASK_ADDR, 32'h0000_0001);
        tick(1);
        chk("irq raised", 1, {31'h0, irq});
        wr_reg(IRQ_ST_ADDR, 32'h0000_0001);
        tick(1);
        chk("irq cleared", 0, {31'h0, irq});
        // transmit start and its clear land on the same edge
        @(posedge clk);
        act[0] <= 1'b1;
        addr <= IRQ_ST_ADDR;
        wdata <= 32'h0000_0001;
        wr <= 1'b1;
        @(posedge clk);
        act[0] <= 1'b0;
        wr <= 1'b0;
        rd_reg(IRQ_ST_ADDR, 32'h0000_0001, "event over clear");
        chk("irq on event", 1, {31'h0, irq});
        tick(ST + 2);
        for (int i = 0; i < 3; i++) begin
            g = 2 + $urandom % (ST - 2);
            act_hit(i, g);
            look(6'h10 | (6'h01 << i), "stretch start");
            tick(ST - 1);
            look(6'h10 | (6'h01 << i), "stretch last");
            tick(1);
            look(6'h10, "stretch over");
        end
        rd_reg(IRQ_ST_ADDR, 32'h0000_0007, "activity status");
        wr_reg(IRQ_ST_ADDR, 32'h0000_001F);
        pol_ev(0, 6, 1);
        look(6'h10, "six pulses");
        pol_ev(0, 1, 0);
        pol_ev(0, 6, 1);
        look(6'h10, "broken run");
        pol_ev(0, 1, 1);
        look(6'h18, "seventh pulse");
        rd_reg(IRQ_ST_ADDR, 32'h0000_0008, "polarity status");
        pol_ev(0, 1, 0);
        look(6'h10, "normal pulse");
        pol_ev(1, 2, 1);
        look(6'h10, "two packets");
        pol_ev(1, 1, 1);
        look(6'h18, "third packet");
        pol_ev(1, 1, 0);
        look(6'h10, "normal packet");
        wr_reg(CTRL_ADDR, 32'h0000_0009);
        act_hit(1, 0);
        @(posedge clk);
        arst_n <= 1'b0;
        look(6'h00, "mid reset lamps");
        tick(2);
        arst_n <= 1'b1;
        rd_reg(CTRL_ADDR, 32'h0000_0008, "ctrl after reset");
        tick(2);
        close_out();
    end
endmodule : tb

`default_nettype wire
